// ---- inc/dpr_pkg.sv ----
// Contract
// - independent mode: port A registers run on clock A, port B on clock B.
// - independent mode: each port has its own enable and clear for its registers.
// - input/output mode: input registers on one clock, data-out registers on another.
// - input/output mode: separate enables and clears for input and output groups.
// - read/write mode: write data, address and strobe registered on the write clock.
// - read/write mode: read address, read strobe and data-out on the read clock.
// - read/write mode: own enable per clock, separate write-side and read-side clears.
// - simple dual-port: read strobe register ignores clear; all others are clearable.
// - single-port mode: one address serves reads and writes, never at once.
// - mid-size block may hold two single-port memories if each is at most 2K bits.
// - each port takes 16-bit address, 8-bit mask, write control, 72-bit data buses.
// - write control alone picks read or write; write needs control and mask bit.
// - mask bit n gates data bits 9n+8..9n; any mix allowed; default all ones.
package dpr_pkg;
  localparam int DATA_W = 72;
  localparam int ADDR_W = 16;
  localparam int ADDR_LO_W = 8;
  localparam int MASK_W = 8;
  localparam int BYTE_W = 9;
  localparam int DEPTH = 8192;
  localparam int SPLIT_MAX_BITS = 2048;
  localparam logic [MASK_W-1:0] MASK_RST = 8'hff;
  localparam logic [DATA_W-1:0] DATA_RST = 72'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0;

  typedef enum logic [1:0] {
    DPR_INDEP = 2'b00,
    DPR_IN_OUT = 2'b01,
    DPR_RD_WR = 2'b10,
    DPR_SINGLE = 2'b11
  } dpr_mode_e;
endpackage : dpr_pkg

// ---- logic/dpr_port_regs.sv ----
`timescale 1ns/1ps
module dpr_port_regs (
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic ce,
  input wire logic clr,
  input wire logic [dpr_pkg::ADDR_W-1:0] addr,
  input wire logic [dpr_pkg::DATA_W-1:0] dataIn,
  input wire logic wren,
  input wire logic [dpr_pkg::MASK_W-1:0] mask,
  output logic [dpr_pkg::ADDR_W-1:0] addrR,
  output logic [dpr_pkg::DATA_W-1:0] dataR,
  output logic wrenR,
  output logic [dpr_pkg::MASK_W-1:0] maskR,
  output logic captured
);
  import dpr_pkg::*;

  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [DATA_W-1:0] data_r, data_nxt;
  logic wren_r, wren_nxt;
  logic [MASK_W-1:0] mask_r, mask_nxt;
  logic cap_r, cap_nxt;

  // input group moves only on its own clock tick with enable
  always_comb begin
    addr_nxt = addr_r;
    data_nxt = data_r;
    wren_nxt = wren_r;
    mask_nxt = mask_r;
    cap_nxt = 1'b0;
    if (tick && ce) begin
      addr_nxt = addr;
      data_nxt = dataIn;
      wren_nxt = wren;
      mask_nxt = mask;
      cap_nxt = 1'b1;
    end
  end

  // clear acts without the clock; mask clears to its all-ones default
  always_ff @(posedge clk or posedge rst or posedge clr) begin
    if (rst || clr) begin
      addr_r <= ADDR_RST;
      data_r <= DATA_RST;
      wren_r <= 1'b0;
      mask_r <= MASK_RST;
      cap_r <= 1'b0;
    end else begin
      addr_r <= addr_nxt;
      data_r <= data_nxt;
      wren_r <= wren_nxt;
      mask_r <= mask_nxt;
      cap_r <= cap_nxt;
    end
  end

  assign addrR = addr_r;
  assign dataR = data_r;
  assign wrenR = wren_r;
  assign maskR = mask_r;
  assign captured = cap_r;
endmodule : dpr_port_regs

// ---- logic/dpr_ram_clocking.sv ----
`timescale 1ns/1ps
module dpr_ram_clocking #(
  parameter int DEPTH = dpr_pkg::DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire dpr_pkg::dpr_mode_e mode,
  input wire logic inTickA,
  input wire logic inCeA,
  input wire logic inClrA,
  input wire logic outTickA,
  input wire logic outCeA,
  input wire logic outClrA,
  input wire logic [dpr_pkg::ADDR_W-1:0] addrA,
  input wire logic [dpr_pkg::DATA_W-1:0] dataInA,
  input wire logic wrenA,
  input wire logic [dpr_pkg::MASK_W-1:0] maskA,
  output logic [dpr_pkg::DATA_W-1:0] dataOutA,
  input wire logic inTickB,
  input wire logic inCeB,
  input wire logic inClrB,
  input wire logic outTickB,
  input wire logic outCeB,
  input wire logic outClrB,
  input wire logic [dpr_pkg::ADDR_W-1:0] addrB,
  input wire logic [dpr_pkg::DATA_W-1:0] dataInB,
  input wire logic wrenB,
  input wire logic [dpr_pkg::MASK_W-1:0] maskB,
  input wire logic rdStrobe,
  output logic [dpr_pkg::DATA_W-1:0] dataOutB
);
  import dpr_pkg::*;

  localparam int IDX_W = $clog2(DEPTH);
  localparam bit SPLIT_OK = ((DEPTH / 2) * DATA_W) <= SPLIT_MAX_BITS;

  logic [ADDR_W-1:0] addrRA, addrRB;
  logic [DATA_W-1:0] dataRA, dataRB;
  logic wrenRA, wrenRB, capA, capB;
  logic [MASK_W-1:0] maskRA, maskRB;

  function automatic logic [DATA_W-1:0] byteMerge(input logic [DATA_W-1:0] old,
                                                   input logic [DATA_W-1:0] nw,
                                                   input logic [MASK_W-1:0] m);
    logic [DATA_W-1:0] res;
    res = old;
    for (int n = 0; n < MASK_W; n++) begin
      if (m[n]) begin
        res[n*BYTE_W +: BYTE_W] = nw[n*BYTE_W +: BYTE_W];
      end
    end
    byteMerge = res;
  endfunction : byteMerge

  // in single-port mode each port owns one half of the array
  function automatic logic [IDX_W-1:0] memIdx(input logic [ADDR_W-1:0] a, input dpr_mode_e m,
                                              input logic portB);
    if (m == DPR_SINGLE) begin
      memIdx = {portB, a[IDX_W-2:0]};
    end else begin
      memIdx = a[IDX_W-1:0];
    end
  endfunction : memIdx

  // input groups always run on each port's own input clock
  dpr_port_regs u_regs_a (
    .clk(clk), .rst(rst), .tick(inTickA), .ce(inCeA), .clr(inClrA),
    .addr(addrA), .dataIn(dataInA), .wren(wrenA), .mask(maskA),
    .addrR(addrRA), .dataR(dataRA), .wrenR(wrenRA), .maskR(maskRA), .captured(capA)
  );
  dpr_port_regs u_regs_b (
    .clk(clk), .rst(rst), .tick(inTickB), .ce(inCeB), .clr(inClrB),
    .addr(addrB), .dataIn(dataInB), .wren(wrenB), .mask(maskB),
    .addrR(addrRB), .dataR(dataRB), .wrenR(wrenRB), .maskR(maskRB), .captured(capB)
  );

  // output group control selection per mode
  logic oTickA, oCeA, oClrA, oTickB, oCeB, oClrB;
  always_comb begin
    oTickA = inTickA;
    oCeA = inCeA;
    oClrA = inClrA;
    oTickB = inTickB;
    oCeB = inCeB;
    oClrB = inClrB;
    case (mode)
      DPR_IN_OUT: begin
        oTickA = outTickA;
        oCeA = outCeA;
        oClrA = outClrA;
        oTickB = outTickB;
        oCeB = outCeB;
        oClrB = outClrB;
      end
      DPR_RD_WR: begin
        oTickA = 1'b0;
        oCeA = 1'b0;
      end
      default: begin
      end
    endcase
  end

  // read strobe register: only the global reset reaches it
  logic rdStrobe_r, rdStrobe_nxt;
  always_comb begin
    rdStrobe_nxt = rdStrobe_r;
    if (inTickB && inCeB) begin
      rdStrobe_nxt = rdStrobe;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdStrobe_r <= 1'b0;
    end else begin
      rdStrobe_r <= rdStrobe_nxt;
    end
  end

  // write enables; read/write mode writes only from the write side
  logic wrEnA, wrEnB;
  logic [IDX_W-1:0] idxA, idxB;
  always_comb begin
    idxA = memIdx(addrRA, mode, 1'b0);
    idxB = memIdx(addrRB, mode, 1'b1);
    wrEnA = capA && wrenRA;
    case (mode)
      DPR_RD_WR: wrEnB = 1'b0;
      DPR_SINGLE: wrEnB = SPLIT_OK && capB && wrenRB;
      default: wrEnB = capB && wrenRB;
    endcase
  end

  logic [DATA_W-1:0] mem_r [DEPTH];
  logic [DATA_W-1:0] mem_nxt [DEPTH];
  always_comb begin
    mem_nxt = mem_r;
    if (wrEnB) begin
      mem_nxt[idxB] = byteMerge(mem_r[idxB], dataRB, maskRB);
    end
    // port A wins a collision on the same word in the bytes its mask enables
    if (wrEnA) begin
      mem_nxt[idxA] = byteMerge(mem_nxt[idxA], dataRA, maskRA);
    end
  end
  always_ff @(posedge clk) begin
    mem_r <= mem_nxt;
  end

  // data-out registers; a writing port in single-port mode does not read
  logic [DATA_W-1:0] outA_r, outA_nxt, outB_r, outB_nxt;
  logic ldA, ldB;
  always_comb begin
    ldA = oTickA && oCeA && !(mode == DPR_SINGLE && wrenRA);
    case (mode)
      DPR_RD_WR: ldB = oTickB && oCeB && rdStrobe_nxt;
      DPR_SINGLE: ldB = SPLIT_OK && oTickB && oCeB && !wrenRB;
      default: ldB = oTickB && oCeB;
    endcase
    outA_nxt = ldA ? mem_r[idxA] : outA_r;
    outB_nxt = ldB ? mem_r[idxB] : outB_r;
  end
  always_ff @(posedge clk or posedge rst or posedge oClrA) begin
    if (rst || oClrA) begin
      outA_r <= DATA_RST;
    end else begin
      outA_r <= outA_nxt;
    end
  end
  always_ff @(posedge clk or posedge rst or posedge oClrB) begin
    if (rst || oClrB) begin
      outB_r <= DATA_RST;
    end else begin
      outB_r <= outB_nxt;
    end
  end
  assign dataOutA = outA_r;
  assign dataOutB = outB_r;

  property holdWhenIdle(logic tk, logic en, logic cl, logic [ADDR_W-1:0] a);
    @(posedge clk) disable iff (rst) (!(tk && en) && !cl) ##1 !cl |-> $stable(a);
  endproperty

  holdAddrA_a: assert property (holdWhenIdle(inTickA, inCeA, inClrA, addrRA))
    else $error("port A address moved while disabled");
  holdAddrB_a: assert property (holdWhenIdle(inTickB, inCeB, inClrB, addrRB))
    else $error("port B address moved while disabled");
  clrOutA_a: assert property (@(posedge clk) disable iff (rst) oClrA |-> outA_r == DATA_RST)
    else $error("port A output not cleared");
  rwNoWriteB_a: assert property (@(posedge clk) disable iff (rst) mode == DPR_RD_WR |-> !wrEnB)
    else $error("read side wrote in read/write mode");
  rwOutHold_a: assert property (@(posedge clk) disable iff (rst)
    (mode == DPR_RD_WR && !inTickB && !inClrB) ##1 !inClrB |-> $stable(outB_r))
    else $error("read data changed without read clock");
  ioOutHold_a: assert property (@(posedge clk) disable iff (rst)
    (mode == DPR_IN_OUT && !outTickA && !outClrA) ##1 !outClrA |-> $stable(outA_r))
    else $error("output register moved off its clock");
  indepOutHold_a: assert property (@(posedge clk) disable iff (rst)
    (mode == DPR_INDEP && !inTickA && !inClrA) ##1 ($stable(mode) && !inClrA) |-> $stable(outA_r))
    else $error("port A output moved off clock A");
  strobeNoClr_a: assert property (@(posedge clk) disable iff (rst)
    (inClrB && !(inTickB && inCeB)) |=> $stable(rdStrobe_r))
    else $error("read strobe reacted to clear");
  maskWrite_a: assert property (@(posedge clk) disable iff (rst)
    (wrEnA && maskRA[0]) |=> mem_r[$past(idxA)][BYTE_W-1:0] == $past(dataRA[BYTE_W-1:0]))
    else $error("masked byte 0 not written");
  maskKeep_a: assert property (@(posedge clk) disable iff (rst)
    (wrEnA && !maskRA[1] && !wrEnB) |=> mem_r[$past(idxA)][2*BYTE_W-1:BYTE_W] ==
      $past(mem_r[idxA][2*BYTE_W-1:BYTE_W]))
    else $error("disabled byte 1 was written");
  splitGate_a: assert property (@(posedge clk) disable iff (rst)
    (mode == DPR_SINGLE && !SPLIT_OK) |-> !wrEnB && !ldB)
    else $error("second single-port memory used beyond size");

  writeA_c: cover property (@(posedge clk) disable iff (rst) wrEnA && maskRA == MASK_RST);
  rwRead_c: cover property (@(posedge clk) disable iff (rst) mode == DPR_RD_WR && ldB);
  bothWrite_c: cover property (@(posedge clk) disable iff (rst) mode == DPR_INDEP && wrEnA && wrEnB);
  singleRead_c: cover property (@(posedge clk) disable iff (rst) mode == DPR_SINGLE && ldA);
endmodule : dpr_ram_clocking

// ---- test/dpr_fabric_ticks.sv ----
`timescale 1ns/1ps
// fabric clock-edge source: a request becomes a one-cycle tick, promptly or one cycle late
module dpr_fabric_ticks (
  input wire logic clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic [3:0] go,
  output logic [3:0] tick
);
  logic [3:0] goDly_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      goDly_r <= 4'h0;
      tick <= 4'h0;
    end else begin
      goDly_r <= go;
      tick <= slow ? goDly_r : go;
    end
  end
endmodule : dpr_fabric_ticks

// ---- test/tb_dpr_ram_clocking.sv ----
`timescale 1ns/1ps
module tb_dpr_ram_clocking;
  import dpr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  dpr_mode_e mode = DPR_INDEP;
  logic slow = 1'b0;
  logic [3:0] go = 4'h0;
  logic [3:0] tick;
  // bit order: input A, output A, input B, output B
  logic [3:0] ce = 4'hf;
  logic [3:0] clr = 4'h0;
  logic [ADDR_W-1:0] addr [2] = '{ADDR_RST, ADDR_RST};
  logic [DATA_W-1:0] din [2] = '{DATA_RST, DATA_RST};
  logic [MASK_W-1:0] mask [2] = '{MASK_RST, MASK_RST};
  logic [1:0] wren = 2'b00;
  logic rdStb = 1'b0;
  logic chk = 1'b0;
  logic [DATA_W-1:0] dout [2];
  logic [DATA_W-1:0] sh [int];
  logic [DATA_W:0] q [$];
  logic [DATA_W:0] e;
  logic [ADDR_W-1:0] a;
  int miscompares = 0;
  int n_compared = 0;
  int seed = 57;
  int rp;

  always #4 clk = ~clk;

  dpr_fabric_ticks fab (.clk(clk), .rst(rst), .slow(slow), .go(go), .tick(tick));

  dpr_ram_clocking dut (
    .clk(clk), .rst(rst), .mode(mode),
    .inTickA(tick[0]), .inCeA(ce[0]), .inClrA(clr[0]), .outTickA(tick[1]), .outCeA(ce[1]), .outClrA(clr[1]),
    .addrA(addr[0]), .dataInA(din[0]), .wrenA(wren[0]), .maskA(mask[0]), .dataOutA(dout[0]),
    .inTickB(tick[2]), .inCeB(ce[2]), .inClrB(clr[2]), .outTickB(tick[3]), .outCeB(ce[3]), .outClrB(clr[3]),
    .addrB(addr[1]), .dataInB(din[1]), .wrenB(wren[1]), .maskB(mask[1]), .rdStrobe(rdStb),
    .dataOutB(dout[1])
  );

  task stop_test;
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  task check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      miscompares++;
    end
  endtask : check

  function logic [DATA_W-1:0] rnd();
    rnd = {8'($random(seed)), $random(seed), $random(seed)};
  endfunction : rnd

  function logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o, input logic [DATA_W-1:0] n,
                                    input logic [MASK_W-1:0] m);
    merge = o;
    for (int b = 0; b < MASK_W; b++) if (m[b]) merge[b*BYTE_W +: BYTE_W] = n[b*BYTE_W +: BYTE_W];
  endfunction : merge

  task pulse(input logic [3:0] g);
    go = g;
    @(posedge clk);
    #1;
    go = 4'h0;
    repeat (int'(slow) + 1) @(posedge clk);
    #1;
  endtask : pulse

  task wr(input int p, input logic [ADDR_W-1:0] wa, input logic [DATA_W-1:0] d,
          input logic [MASK_W-1:0] m, input bit ok);
    addr[p] = wa;
    din[p] = d;
    mask[p] = m;
    wren[p] = 1'b1;
    pulse(4'h1 << (2 * p));
    if (ok) sh[wa] = merge(sh[wa], d, m);
  endtask : wr

  task rd(input int p, input logic [ADDR_W-1:0] ra, input bit stb);
    logic [3:0] g;
    g = 4'h1 << (2 * p);
    addr[p] = ra;
    wren[p] = 1'b0;
    rdStb = stb;
    pulse(g);
    pulse(mode == DPR_IN_OUT ? g << 1 : g);
    q.push_back({1'(p), stb ? sh[ra] : DATA_RST});
    chk = 1'b1;
    @(posedge clk);
    #1;
    chk = 1'b0;
  endtask : rd

  // clears the read port's output group asynchronously and looks at once
  task clrchk(input int p);
    int k;
    k = (mode == DPR_IN_OUT) ? 2 * p + 1 : 2 * p;
    clr[k] = 1'b1;
    #1;
    check(dout[p], DATA_RST);
    @(posedge clk);
    #1;
    clr[k] = 1'b0;
  endtask : clrchk

  task reset_dut(input dpr_mode_e m);
    rst = 1'b1;
    mode = m;
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    check(dout[0], DATA_RST);
    check(dout[1], DATA_RST);
  endtask : reset_dut

  always @(negedge clk) begin
    if (chk) begin
      e = q.pop_front();
      check(dout[e[DATA_W]], e[DATA_W-1:0]);
    end
  end

  initial begin
    for (int mi = 0; mi < 4; mi++) begin
      reset_dut(dpr_mode_e'(mi));
      slow = mi[0];
      rp = (mode == DPR_RD_WR) ? 1 : 0;
      for (int i = 0; i < 4; i++) begin
        a = 16'(i * 37 + 3);
        wr(0, a, rnd(), 8'hff, 1'b1);
        wr(0, a, rnd(), 8'($random(seed)), 1'b1);
        rd(rp, a, 1'b1);
      end
      if (mode == DPR_INDEP || mode == DPR_IN_OUT) begin
        wr(1, 16'h00c8, rnd(), 8'hff, 1'b1);
        wr(1, 16'h00c8, rnd(), 8'h5a, 1'b1);
        rd(1, 16'h00c8, 1'b1);
      end
      ce[0] = 1'b0;
      wr(0, 16'h0003, rnd(), 8'hff, 1'b0);
      ce[0] = 1'b1;
      rd(rp, 16'h0003, 1'b1);
      if (mode == DPR_RD_WR) begin
        wr(1, 16'h0003, rnd(), 8'hff, 1'b0);
        rd(1, 16'h0003, 1'b1);
      end
      clrchk(rp);
      if (mode == DPR_RD_WR) begin
        rd(1, 16'h0003, 1'b0);
        check(dout[0], DATA_RST);
      end
    end
    stop_test;
  end

  initial begin
    #40000;
    miscompares++;
    stop_test;
  end
endmodule : tb_dpr_ram_clocking
